// File: hdl/ecb_map.svh
// Constants for the external cache bus control block.
`ifndef ECB_MAP_SVH
`define ECB_MAP_SVH
`define ECB_TAG_W          16
`define ECB_WSEL_LO        2'h0
`define ECB_WSEL_Q1        2'h1
`define ECB_WSEL_HI        2'h2
`define ECB_WSEL_Q3        2'h3
`define ECB_WORDS_PER_BLK  4
`define ECB_SEL_ALL        4'hf
`endif

// File: hdl/ecb_pkg.sv
// Types shared by the external cache bus control block.
`default_nettype none
package ecb_pkg;
  typedef enum logic [4:0] {
    ECB_IDLE  = 5'h01,
    ECB_TAG   = 5'h02,
    ECB_DATA  = 5'h04,
    ECB_HOLD  = 5'h08,
    ECB_WRITE = 5'h10
  } ecb_state_t;
  typedef struct packed {
    logic valid;
    logic shared;
    logic dirty;
  } ecb_line_state_t;
endpackage : ecb_pkg
`default_nettype wire

// File: hdl/ecb_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/10ps
`default_nettype none
module ecb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Stage one feeds only stage two.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // ecb_sync
`default_nettype wire

// File: hdl/ecb_ctrl.sv
// External cache bus control: RAM enables, tag check, hold and write-chunk select.
// Functional notes
// R1: Check tag parity with address on lookup.
// R2: Tag-ready pair can stall; access is held.
// R3: Early variant drives tag match during hold.
// R4: Drive four data RAM enables during accesses.
// R5: Drive four data RAM write enables.
// R6: Drive data address bits 4:3 sequencing words.
// R7: System logic requests hold to own RAMs.
// R8: Grant output shows system owns the RAMs.
// R9: Backmap write enable pulses on cache reads.
// R10: Later variant: two backmap lines per half; code drives one line per half (bit 0 for half 0, bit 1 for half 1).
// R11: Drive write data when drive input low.
// R12: Write select picks write-block bytes driven.
// R13: Drive tag RAM enable during accesses.
// R14: Line state from valid, shared, dirty bits.
// R15: Release outputs while granted; resume after release.
`timescale 1ns/10ps
`default_nettype none
`include "ecb_map.svh"
module ecb_ctrl #(
  parameter int  TAG_W    = `ECB_TAG_W,
  parameter bit  LATER    = 1'b1,
  parameter bit  BUS_128  = 1'b1
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // Core request side
  input  wire logic              i_req,
  input  wire logic              i_req_write,
  input  wire logic [TAG_W-1:0]  i_req_tag,
  input  wire logic              i_req_dc_half,
  input  wire logic [255:0]      i_wr_block,
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_hit,
  output logic                   o_parity_err,
  output logic                   o_line_valid,
  output logic                   o_line_shared,
  output logic                   o_line_dirty,
  // Tag RAM pins
  input  wire logic [TAG_W-1:0]  i_tag_addr,
  input  wire logic              i_tag_addr_parity_in,
  input  wire logic              i_line_valid_bit,
  input  wire logic              i_line_shared_bit,
  input  wire logic              i_line_dirty_bit,
  input  wire logic              i_tag_ready_pos,
  input  wire logic              i_tag_ready_neg,
  output logic                   o_tag_ram_enable,
  output logic                   o_tag_match_n,
  // Data RAM pins
  output logic [3:0]             o_data_ram_enable,
  output logic [3:0]             o_data_ram_write_en,
  output logic [1:0]             o_data_ram_low_addr,
  output logic [1:0]             o_backmap_write_en,
  // Hold pins
  input  wire logic              i_cache_hold_request,
  output logic                   o_cache_hold_grant,
  // Write data pins
  input  wire logic              i_write_data_drive_n,
  input  wire logic [1:0]        i_write_chunk_select,
  output logic [127:0]           o_data,
  output logic                   o_data_oe
);
  localparam int SW = TAG_W + 10;

  logic [SW-1:0] s_raw;
  logic [SW-1:0] s_sync;
  logic [TAG_W-1:0] tag_s;
  logic tpar_s, v_s, sh_s, d_s, rdy_p_s, rdy_n_s, hreq_s, drv_s;
  logic [1:0] wsel_s;
  logic tag_ok, par_ok, eq;

  // Every pin input passes the two-flop synchroniser.
  // The drive request is inverted first, so a cleared synchroniser reads as not driving.
  assign s_raw = {i_tag_addr, i_tag_addr_parity_in, i_line_valid_bit, i_line_shared_bit,
                  i_line_dirty_bit, i_tag_ready_pos, i_tag_ready_neg, i_cache_hold_request,
                  ~i_write_data_drive_n, i_write_chunk_select};

  ecb_sync #(.W(SW)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (s_raw),
    .o_sync    (s_sync)
  );

  assign {tag_s, tpar_s, v_s, sh_s, d_s, rdy_p_s, rdy_n_s, hreq_s, drv_s, wsel_s} = s_sync;

  // Ready only when the complementary pair agrees; otherwise the access stalls.
  assign tag_ok = rdy_p_s & ~rdy_n_s; // R2
  // Parity taken over the tag bits together with the parity pin, even sense.
  assign par_ok = ~(^{tag_s, tpar_s}); // R1
  assign eq     = (tag_s == i_req_tag);

  ecb_pkg::ecb_state_t state_q, state_d;
  logic [1:0] word_q, word_d;
  logic hit_q, hit_d, perr_q, perr_d, done_q, done_d;
  ecb_pkg::ecb_line_state_t ls_q, ls_d;
  logic wr_q, wr_d, half_q, half_d;
  logic [127:0] data_q, data_d;
  logic oe_q, oe_d;

  // Next-state logic for the access sequencer.
  always_comb begin
    state_d = state_q;
    word_d  = word_q;
    hit_d   = hit_q;
    perr_d  = perr_q;
    done_d  = 1'b0;
    ls_d    = ls_q;
    wr_d    = wr_q;
    half_d  = half_q;
    case (state_q)
      ecb_pkg::ECB_IDLE: begin
        if (hreq_s) begin
          state_d = ecb_pkg::ECB_HOLD; // R7
        end else if (i_req) begin
          wr_d    = i_req_write;
          half_d  = i_req_dc_half;
          word_d  = 2'h0;
          state_d = ecb_pkg::ECB_TAG;
        end
      end
      ecb_pkg::ECB_TAG: begin
        if (tag_ok) begin // R2
          perr_d = ~par_ok; // R1
          hit_d  = eq & v_s & par_ok;
          ls_d   = '{valid: v_s, shared: v_s & sh_s, dirty: v_s & d_s}; // R14
          state_d = ecb_pkg::ECB_DATA;
        end
      end
      ecb_pkg::ECB_DATA: begin
        if (tag_ok) begin // R2
          if (word_q == 2'(`ECB_WORDS_PER_BLK - 1)) begin
            done_d  = 1'b1;
            state_d = ecb_pkg::ECB_IDLE;
          end else begin
            word_d = word_q + 2'h1; // R6
          end
        end
      end
      ecb_pkg::ECB_HOLD: begin
        if (!hreq_s) begin
          state_d = ecb_pkg::ECB_IDLE; // R15
        end
      end
      default: begin
        state_d = ecb_pkg::ECB_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ecb_pkg::ECB_IDLE;
      word_q  <= 2'h0;
      hit_q   <= 1'b0;
      perr_q  <= 1'b0;
      done_q  <= 1'b0;
      ls_q    <= '0;
      wr_q    <= 1'b0;
      half_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      word_q  <= word_d;
      hit_q   <= hit_d;
      perr_q  <= perr_d;
      done_q  <= done_d;
      ls_q    <= ls_d;
      wr_q    <= wr_d;
      half_q  <= half_d;
    end
  end

  // Write data chunk selection and bus drive.
  always_comb begin
    oe_d   = drv_s; // R11
    data_d = data_q;
    if (drv_s) begin
      if (BUS_128) begin
        data_d = wsel_s[1] ? i_wr_block[255:128] : i_wr_block[127:0]; // R12
      end else begin
        case (wsel_s) // R12
          `ECB_WSEL_LO: data_d = {64'h0, i_wr_block[63:0]};
          `ECB_WSEL_Q1: data_d = {64'h0, i_wr_block[127:64]};
          `ECB_WSEL_HI: data_d = {64'h0, i_wr_block[191:128]};
          `ECB_WSEL_Q3: data_d = {64'h0, i_wr_block[255:192]};
          default:      data_d = 128'h0;
        endcase
      end
    end
  end

  // Write data registers.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      data_q <= 128'h0;
      oe_q   <= 1'b0;
    end else begin
      data_q <= data_d;
      oe_q   <= oe_d;
    end
  end

  logic in_acc;
  assign in_acc = (state_q == ecb_pkg::ECB_TAG) || (state_q == ecb_pkg::ECB_DATA);

  // RAM control outputs; all but the early variant's tag match quiet while the system holds the cache.
  assign o_tag_ram_enable    = (state_q == ecb_pkg::ECB_TAG); // R13 R15
  assign o_data_ram_enable   = (state_q == ecb_pkg::ECB_DATA) ? `ECB_SEL_ALL : 4'h0; // R4
  assign o_data_ram_write_en = (state_q == ecb_pkg::ECB_DATA && wr_q) ? `ECB_SEL_ALL : 4'h0; // R5
  assign o_data_ram_low_addr = in_acc ? word_q : 2'h0; // R6
  // Backmap is written on the last word of a read fill.
  always_comb begin
    o_backmap_write_en = 2'h0;
    if (state_q == ecb_pkg::ECB_DATA && !wr_q && tag_ok &&
        word_q == 2'(`ECB_WORDS_PER_BLK - 1)) begin // R9
      if (LATER) begin
        o_backmap_write_en = half_q ? 2'h2 : 2'h1; // R10
      end else begin
        o_backmap_write_en = 2'h1;
      end
    end
  end
  assign o_cache_hold_grant  = (state_q == ecb_pkg::ECB_HOLD); // R8
  // Only the early variant reports the comparison during hold.
  assign o_tag_match_n = ~(!LATER && state_q == ecb_pkg::ECB_HOLD && eq); // R3
  assign o_busy        = (state_q != ecb_pkg::ECB_IDLE);
  assign o_done        = done_q;
  assign o_hit         = hit_q;
  assign o_parity_err  = perr_q;
  assign o_line_valid  = ls_q.valid;
  assign o_line_shared = ls_q.shared;
  assign o_line_dirty  = ls_q.dirty;
  assign o_data        = data_q;
  assign o_data_oe     = oe_q;
endmodule // ecb_ctrl
`default_nettype wire

// File: testbench/ecb_ctrl_chk.sv
// Concurrent checks on the pins of the external cache bus control block.
`timescale 1ns/10ps
`default_nettype none
module ecb_ctrl_chk (
  // Clock, reset and watched inputs
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_tag_ready_pos,
  input wire logic       i_cache_hold_request,
  input wire logic       i_write_data_drive_n,
  // Watched outputs
  input wire logic       o_done,
  input wire logic       o_tag_ram_enable,
  input wire logic       o_tag_match_n,
  input wire logic [3:0] o_data_ram_enable,
  input wire logic [3:0] o_data_ram_write_en,
  input wire logic [1:0] o_data_ram_low_addr,
  input wire logic [1:0] o_backmap_write_en,
  input wire logic       o_cache_hold_grant,
  input wire logic       o_data_oe
);
  // Every check shares the one clock and reset.
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_GRANT_QUIET: assert property (
    o_cache_hold_grant |-> !o_tag_ram_enable && o_data_ram_enable == 4'h0
    && o_data_ram_write_en == 4'h0) else $error("RAM driven under grant");
  AST_MATCH_IDLE: assert property (!o_cache_hold_grant |-> o_tag_match_n)
    else $error("Tag match outside hold");
  AST_WE_WITH_EN: assert property (
    o_data_ram_write_en != 4'h0 |-> o_data_ram_enable == 4'hf) else $error("Lone write");
  AST_ADDR_START: assert property (
    $rose(o_data_ram_enable[0]) |-> o_data_ram_low_addr == 2'h0) else $error("Bad first word");
  AST_STALL_HOLD: assert property (
    o_data_ram_enable[0] && !$past(i_tag_ready_pos, 2)
    |=> o_data_ram_enable[0] && $stable(o_data_ram_low_addr)) else $error("Stall ignored");
  AST_DONE_AFTER: assert property (
    o_done |-> $past(o_data_ram_low_addr) == 2'h3 && $past(o_data_ram_enable[0]))
    else $error("Done without last word");
  AST_BACKMAP_READ: assert property (
    o_backmap_write_en != 2'h0 |-> o_data_ram_enable[0] && o_data_ram_write_en == 4'h0
    && o_data_ram_low_addr == 2'h3) else $error("Backmap outside read");
  AST_BACKMAP_ONE: assert property ($onehot0(o_backmap_write_en))
    else $error("Both backmap lines");
  AST_OE_ON: assert property ((!i_write_data_drive_n) [*4] |-> o_data_oe)
    else $error("Data not driven");
  AST_OE_OFF: assert property (i_write_data_drive_n [*4] |-> !o_data_oe)
    else $error("Data driven unasked");
  AST_GRANT_DROP: assert property ((!i_cache_hold_request) [*5] |-> !o_cache_hold_grant)
    else $error("Grant without request");
endmodule // ecb_ctrl_chk
bind ecb_ctrl ecb_ctrl_chk u_chk (
  .i_sys_clk, .i_rst, .i_tag_ready_pos, .i_cache_hold_request, .i_write_data_drive_n,
  .o_done, .o_tag_ram_enable, .o_tag_match_n, .o_data_ram_enable, .o_data_ram_write_en,
  .o_data_ram_low_addr, .o_backmap_write_en, .o_cache_hold_grant, .o_data_oe
);
`default_nettype wire

// File: testbench/ecb_far_model.sv
// Far side model: tag RAM contents, line state and the ready pair.
`timescale 1ns/10ps
`default_nettype none
module ecb_far_model #(
  parameter logic [15:0] TAG = 16'h5a3c
) (
  // Commands from the bench
  input  wire logic  i_stall,
  input  wire logic  i_bad_par,
  // Tag RAM and ready lines
  output logic [15:0] o_tag,
  output logic        o_par,
  output logic [2:0]  o_state,
  output logic        o_rdy_pos,
  output logic        o_rdy_neg
);
  // Even parity over tag and parity bit, spoiled only on command.
  assign o_tag = TAG;
  assign o_par = ^TAG ^ i_bad_par;
  assign o_state = 3'h5;
  // Complementary pair, both turned round while stalling.
  assign o_rdy_pos = !i_stall;
  assign o_rdy_neg = i_stall;
endmodule // ecb_far_model
`default_nettype wire

// File: testbench/tb_external_cache_bus_control.sv
// Self-checking testbench for the external cache bus control block.
`timescale 1ns/10ps
`default_nettype none
module tb_external_cache_bus_control;
  localparam logic [15:0] TAG = 16'h5a3c;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, req = 1'b0, req_w = 1'b0, half = 1'b0;
  logic hold = 1'b0, drv_n = 1'b1, stall = 1'b0, bad = 1'b0;
  logic [15:0] req_tag = TAG, tag;
  logic [255:0] blk = '0;
  logic [1:0] wsel = 2'h0, da, bm, bm_seen;
  logic [2:0] st;
  logic [3:0] den, dwe;
  logic [127:0] dout, dout_e;
  logic gnt_e, tmn_e;
  logic busy, done, hit, perr, lv, ls, ld, par, rp, rn, ten, tmn, gnt, doe;
  int n_mismatch = 0, n_compared = 0, cyc = 0, en_n, tag_n, we_n;
  // Clock source.
  always #20 i_sys_clk = ~i_sys_clk;
  ecb_far_model #(.TAG(TAG)) u_far (.i_stall(stall), .i_bad_par(bad), .o_tag(tag),
    .o_par(par), .o_state(st), .o_rdy_pos(rp), .o_rdy_neg(rn));
  ecb_ctrl dut (.i_sys_clk, .i_rst, .i_req(req), .i_req_write(req_w), .i_req_tag(req_tag),
    .i_req_dc_half(half), .i_wr_block(blk), .o_busy(busy), .o_done(done), .o_hit(hit),
    .o_parity_err(perr), .o_line_valid(lv), .o_line_shared(ls), .o_line_dirty(ld),
    .i_tag_addr(tag), .i_tag_addr_parity_in(par), .i_line_valid_bit(st[2]),
    .i_line_shared_bit(st[1]), .i_line_dirty_bit(st[0]), .i_tag_ready_pos(rp),
    .i_tag_ready_neg(rn), .o_tag_ram_enable(ten), .o_tag_match_n(tmn),
    .o_data_ram_enable(den), .o_data_ram_write_en(dwe), .o_data_ram_low_addr(da),
    .o_backmap_write_en(bm), .i_cache_hold_request(hold), .o_cache_hold_grant(gnt),
    .i_write_data_drive_n(drv_n), .i_write_chunk_select(wsel), .o_data(dout), .o_data_oe(doe));
  // Early variant on a 64-bit bus runs beside the main one on the same stimulus.
  ecb_ctrl #(.LATER(1'b0), .BUS_128(1'b0)) dut_early (.i_sys_clk, .i_rst, .i_req(req),
    .i_req_write(req_w), .i_req_tag(req_tag), .i_req_dc_half(half), .i_wr_block(blk),
    .o_busy(), .o_done(), .o_hit(), .o_parity_err(), .o_line_valid(), .o_line_shared(),
    .o_line_dirty(), .i_tag_addr(tag), .i_tag_addr_parity_in(par), .i_line_valid_bit(st[2]),
    .i_line_shared_bit(st[1]), .i_line_dirty_bit(st[0]), .i_tag_ready_pos(rp),
    .i_tag_ready_neg(rn), .o_tag_ram_enable(), .o_tag_match_n(tmn_e),
    .o_data_ram_enable(), .o_data_ram_write_en(), .o_data_ram_low_addr(),
    .o_backmap_write_en(), .i_cache_hold_request(hold), .o_cache_hold_grant(gnt_e),
    .i_write_data_drive_n(drv_n), .i_write_chunk_select(wsel), .o_data(dout_e),
    .o_data_oe());
  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One whole access, tallying the pins seen at each falling edge.
  task automatic access(input logic w, input int exp_en);
    bm_seen = 2'h0;
    en_n = 0;
    tag_n = 0;
    we_n = 0;
    req_w = w;
    req = 1'b1;
    @(negedge i_sys_clk);
    req = 1'b0;
    for (int k = 0; k < 40 && done !== 1'b1; k++) begin
      bm_seen |= bm;
      en_n += int'(den[0]);
      tag_n += int'(ten);
      we_n += int'(dwe[0]);
      @(negedge i_sys_clk);
    end
    chk(done, 1'b1);
    chk(en_n, exp_en);
  endtask
  task automatic t_reads;
    for (int h = 0; h < 2; h++) begin
      half = h[0];
      access(1'b0, 4);
      chk(we_n, 0);
      chk(tag_n, 1);
      chk(bm_seen, h ? 2'h2 : 2'h1);
      chk({hit, perr}, 2'h2);
      chk({lv, ls, ld}, 3'h5);
    end
  endtask
  task automatic t_write_stall;
    // Stall the tag phase for seven cycles, then the second word for three.
    stall = 1'b1;
    req_tag = ~TAG;
    repeat (3) @(negedge i_sys_clk);
    fork
      access(1'b1, 7);
      begin
        repeat (6) @(negedge i_sys_clk);
        stall = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        stall = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        stall = 1'b0;
      end
    join
    chk(we_n, 7);
    chk({bm_seen, hit}, 3'h0);
    chk(tag_n, 8);
    req_tag = TAG;
  endtask
  task automatic t_parity;
    bad = 1'b1;
    // Let the spoiled parity pass the synchroniser before the lookup.
    repeat (2) @(negedge i_sys_clk);
    access(1'b0, 4);
    chk({hit, perr}, 2'h1);
    bad = 1'b0;
  endtask
  task automatic t_hold;
    hold = 1'b1;
    for (int k = 0; k < 10 && gnt !== 1'b1; k++) @(negedge i_sys_clk);
    chk(gnt, 1'b1);
    req = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk({busy, ten, den, tmn}, 7'h41);
    chk({gnt_e, tmn_e}, 2'h2);
    req = 1'b0;
    hold = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    chk(gnt, 1'b0);
    chk(tmn_e, 1'b1);
    access(1'b0, 4);
  endtask
  task automatic t_wsel;
    for (int b = 0; b < 32; b++) blk[8*b +: 8] = 8'(b + 8'ha0);
    drv_n = 1'b0;
    for (int s = 0; s < 4; s++) begin
      wsel = s[1:0];
      repeat (4) @(negedge i_sys_clk);
      chk(dout, wsel[1] ? blk[255:128] : blk[127:0]);
      chk(dout_e, {64'h0, blk[64*s +: 64]});
      chk(doe, 1'b1);
    end
    drv_n = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    chk(doe, 1'b0);
  endtask
  // Cuts a hung run short.
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // Main sequence.
  initial begin
    repeat (12) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    t_reads();
    t_write_stall();
    t_parity();
    t_hold();
    t_wsel();
    complete_run();
  end
endmodule // tb_external_cache_bus_control
`default_nettype wire
